// >>> core/tcoc_pkg.sv
// Constants, register map and carrier types of the timer compare output block.
// Assumes a 16-bit register port and a port pin block on the same system clock.
package tcoc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 3;
  localparam int NUM_FLAGS = 5;
  localparam int PRE_W = 10;

  // Register offsets, one 16-bit register each
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_OUT_MODE = 4'h1;
  localparam logic [3:0] REG_FORCE = 4'h2;
  localparam logic [3:0] REG_COUNTER = 4'h3;
  localparam logic [3:0] REG_COMPARE_A = 4'h4;
  localparam logic [3:0] REG_COMPARE_B = 4'h5;
  localparam logic [3:0] REG_COMPARE_C = 4'h6;
  localparam logic [3:0] REG_CAPTURE = 4'h7;
  localparam logic [3:0] REG_FLAGS = 4'h8;
  localparam logic [3:0] REG_OUT_BITS = 4'h9;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CLK_LSB = 4;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_LSB = 1;
  localparam int FLAG_CAP_BIT = 4;

  // Waveform modes handled as non-PWM
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;

  // Clock select codes and prescaler masks (factor minus one)
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] PRE_MASK_1 = 10'h000;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

  // Reset values and extremes
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] REG_RST = 16'h0000;

  // Non-PWM match actions of channel_output_mode
  typedef enum logic [1:0] {
    TCOC_OM_NONE   = 2'b00,
    TCOC_OM_TOGGLE = 2'b01,
    TCOC_OM_CLEAR  = 2'b10,
    TCOC_OM_SET    = 2'b11
  } tcoc_out_mode_type;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tcoc_bus_req_type;

  typedef struct packed {
    logic [2:0] value;
    logic [2:0] oe_n;
  } tcoc_pin_type;

endpackage : tcoc_pkg

// >>> core/tcoc_timer_compare_output.sv
// 16-bit timer with compare output units, normal and clear-on-match counting.
// Assumes a register master on sys_clk and port pin logic on sys_clk.
// Function
// - Nonzero output mode replaces the port value with the compare output bit.
// - Pin direction bit still decides whether the pin drives.
// - Reset clears every compare output bit.
// - Compare output bit can be set while the pin is not driving.
// - Output mode has no influence on capture.
// - Output mode zero leaves the compare output bit unchanged on matches.
// - New output mode acts at once: the pin source switches in the cycle after the write.
// - Force strobe applies the output action at once in non-PWM modes.
// - Only the waveform mode sets the counting sequence.
// - PWM modes pick polarity; non-PWM modes pick set, clear or toggle.
// - Normal mode only increments and wraps from FFFF to 0000.
// - Normal mode sets overflow flag as the counter becomes zero.
// - Counting only sets overflow; interrupt acknowledge clears it.
// - Counter writes are accepted at any time in normal mode.
// - Clear-on-match clears at top: compare A in mode 4, capture in 12.
// - Reaching top sets compare A flag or capture flag, matching the top source.
// - Top writes act unbuffered; a top below count wraps through FFFF first.
// - Toggle mode in clear-on-match toggles channel A bit on each match.
// - Toggle frequency follows prescaler 1, 8, 64, 256 or 1024 and compare value.
// - Clear-on-match sets overflow flag as the counter passes MAX to zero.
// - Forced compare touches no flag and no counter.
// - A match sets the compare flag; writing one clears it.
// - A counter write suppresses matches at the next timer tick.
`timescale 1ns/1ps

module tcoc_timer_compare_output (
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  input  wire tcoc_pkg::tcoc_bus_req_type bus_req,
  output logic [15:0]                    bus_rdata,
  input  wire logic [2:0]                port_value,
  input  wire logic [2:0]                pin_direction_bit,
  input  wire logic                      capture_event,
  input  wire logic [4:0]                flag_int_ack,
  output tcoc_pkg::tcoc_pin_type         pin_drive,
  output logic [2:0]                     compare_output_bit,
  output logic [4:0]                     flag_status
);

  // Software registers
  logic [3:0]  waveform_mode;
  logic [2:0]  clock_select;
  logic [5:0]  channel_output_mode;
  logic [15:0] counter_value;
  logic [15:0] channel_compare_value [tcoc_pkg::NUM_CH];
  logic [15:0] capture_register;
  logic [4:0]  flags;

  // Timer internals
  logic [9:0]  pre_count;
  logic        match_block;

  // Decoded bus strobes
  wire wr_control  = bus_req.wr && (bus_req.addr == tcoc_pkg::REG_CONTROL);
  wire wr_out_mode = bus_req.wr && (bus_req.addr == tcoc_pkg::REG_OUT_MODE);
  wire wr_force    = bus_req.wr && (bus_req.addr == tcoc_pkg::REG_FORCE);
  wire wr_counter  = bus_req.wr && (bus_req.addr == tcoc_pkg::REG_COUNTER);
  wire wr_capture  = bus_req.wr && (bus_req.addr == tcoc_pkg::REG_CAPTURE);
  wire wr_flags    = bus_req.wr && (bus_req.addr == tcoc_pkg::REG_FLAGS);

  // Mode decode
  wire mode_normal  = waveform_mode == tcoc_pkg::MODE_NORMAL;
  wire mode_ctc_a   = waveform_mode == tcoc_pkg::MODE_CTC_A;
  wire mode_ctc_cap = waveform_mode == tcoc_pkg::MODE_CTC_CAP;
  wire mode_ctc     = mode_ctc_a || mode_ctc_cap;
  wire non_pwm      = mode_normal || mode_ctc;

  // Prescaler: timer tick once per N system clocks
  wire [9:0] pre_mask =
    (clock_select == tcoc_pkg::CS_DIV1)    ? tcoc_pkg::PRE_MASK_1 :
    (clock_select == tcoc_pkg::CS_DIV8)    ? tcoc_pkg::PRE_MASK_8 :
    (clock_select == tcoc_pkg::CS_DIV64)   ? tcoc_pkg::PRE_MASK_64 :
    (clock_select == tcoc_pkg::CS_DIV256)  ? tcoc_pkg::PRE_MASK_256 :
                                             tcoc_pkg::PRE_MASK_1024;
  wire running = (clock_select != tcoc_pkg::CS_STOP) &&
                 (clock_select <= tcoc_pkg::CS_DIV1024);
  wire tick    = running && ((pre_count & pre_mask) == pre_mask);
  wire [9:0] next_pre_count = running ? pre_count + 10'h001 : 10'h000;

  // Top of the clear-on-match sequence, compared unbuffered
  wire [15:0] top_value = mode_ctc_cap ? capture_register
                                       : channel_compare_value[0];
  wire top_hit = tick && !match_block && mode_ctc &&
                 (counter_value == top_value);

  // Counter: software write wins over counting at any time
  wire [15:0] count_inc = counter_value + 16'h0001;
  wire [15:0] next_counter_value =
    wr_counter ? bus_req.wdata :
    !tick      ? counter_value :
    top_hit    ? tcoc_pkg::COUNT_RST :
                 count_inc;

  // Overflow whenever a tick moves MAX to zero
  wire overflow_set = tick && !wr_counter &&
                      (counter_value == tcoc_pkg::COUNT_MAX);

  // Block lasts until the next tick, even while stopped
  wire next_match_block = wr_counter ? 1'b1 :
                          tick       ? 1'b0 :
                                       match_block;

  // Capture unit is disabled while the capture register defines top
  wire capture_take = capture_event && !mode_ctc_cap;
  wire [15:0] next_capture_register =
    wr_capture   ? bus_req.wdata :
    capture_take ? counter_value :
                   capture_register;

  // Flags: set wins over a same-cycle clear
  logic [2:0] match;
  wire  [4:0] flag_set;
  wire  [4:0] flag_clear = (wr_flags ? bus_req.wdata[4:0] : 5'h00) |
                           flag_int_ack;
  assign flag_set[tcoc_pkg::FLAG_OVF_BIT] = overflow_set;
  assign flag_set[tcoc_pkg::FLAG_CMP_LSB +: tcoc_pkg::NUM_CH] = match;
  assign flag_set[tcoc_pkg::FLAG_CAP_BIT] = capture_take ||
                                            (top_hit && mode_ctc_cap);
  wire [4:0] next_flags = (flags & ~flag_clear) | flag_set;

  // Control fields; only waveform_mode shapes the counting sequence
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      waveform_mode <= 4'h0;
      clock_select  <= tcoc_pkg::CS_STOP;
    end else if (wr_control) begin
      waveform_mode <= bus_req.wdata[tcoc_pkg::CTRL_MODE_LSB +: 4];
      clock_select  <= bus_req.wdata[tcoc_pkg::CTRL_CLK_LSB +: 3];
    end
  end

  // Not double buffered: a new field is seen by the very next match
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      channel_output_mode <= 6'h00;
    end else if (wr_out_mode) begin
      channel_output_mode <= bus_req.wdata[5:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      counter_value <= tcoc_pkg::COUNT_RST;
    end else begin
      counter_value <= next_counter_value;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      capture_register <= tcoc_pkg::REG_RST;
    end else begin
      capture_register <= next_capture_register;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags <= 5'h00;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pre_count <= 10'h000;
    end else begin
      pre_count <= next_pre_count;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      match_block <= 1'b0;
    end else begin
      match_block <= next_match_block;
    end
  end

  // Enum names used inside the generate
  localparam tcoc_pkg::tcoc_out_mode_type TCOC_OM_NONE_C   = tcoc_pkg::TCOC_OM_NONE;
  localparam tcoc_pkg::tcoc_out_mode_type TCOC_OM_TOGGLE_C = tcoc_pkg::TCOC_OM_TOGGLE;
  localparam tcoc_pkg::tcoc_out_mode_type TCOC_OM_CLEAR_C  = tcoc_pkg::TCOC_OM_CLEAR;
  localparam tcoc_pkg::tcoc_out_mode_type TCOC_OM_SET_C    = tcoc_pkg::TCOC_OM_SET;

  // Per-channel compare unit and pin override
  for (genvar ch = 0; ch < tcoc_pkg::NUM_CH; ch++) begin : g_ch
    wire [1:0] mode_bits = channel_output_mode[2 * ch +: 2];
    wire       wr_cmp    = bus_req.wr &&
                           (bus_req.addr == tcoc_pkg::REG_COMPARE_A + 4'(ch));
    wire       forced    = wr_force && bus_req.wdata[ch] && non_pwm;
    wire       act       = match[ch] || forced;
    logic      next_bit;

    // Matches only on a tick, and never in the tick after a counter write
    assign match[ch] = tick && !match_block &&
                       (counter_value == channel_compare_value[ch]);

    always_comb begin
      next_bit = compare_output_bit[ch];
      if (act && non_pwm) begin
        unique case (mode_bits)
          TCOC_OM_TOGGLE_C: next_bit = ~compare_output_bit[ch];
          TCOC_OM_CLEAR_C:  next_bit = 1'b0;
          TCOC_OM_SET_C:    next_bit = 1'b1;
          TCOC_OM_NONE_C:   next_bit = compare_output_bit[ch];
        endcase
      end else if (act) begin
        // Polarity only; nothing in this block makes a bottom-of-cycle edge
        unique case (mode_bits)
          TCOC_OM_CLEAR_C:  next_bit = 1'b1;
          TCOC_OM_SET_C:    next_bit = 1'b0;
          TCOC_OM_TOGGLE_C: next_bit = compare_output_bit[ch];
          TCOC_OM_NONE_C:   next_bit = compare_output_bit[ch];
        endcase
      end
    end

    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        compare_output_bit[ch] <= 1'b0;
      end else begin
        compare_output_bit[ch] <= next_bit;
      end
    end

    // Unbuffered in the non-PWM modes: a write is compared at once
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        channel_compare_value[ch] <= tcoc_pkg::REG_RST;
      end else if (wr_cmp) begin
        channel_compare_value[ch] <= bus_req.wdata;
      end
    end

    // Override the port value; direction still comes from the port
    assign pin_drive.value[ch] = (mode_bits != 2'b00) ? compare_output_bit[ch]
                                                      : port_value[ch];
    assign pin_drive.oe_n[ch]  = ~pin_direction_bit[ch];
  end

  // Register images, zero-padded to the bus width
  wire [15:0] img_control  = {9'h000, clock_select, waveform_mode};
  wire [15:0] img_out_mode = {10'h000, channel_output_mode};
  wire [15:0] img_flags    = {11'h000, flags};
  wire [15:0] img_out_bits = {13'h0000, compare_output_bit};

  // Read selection; force register reads as zero, unmapped reads as zero
  wire [15:0] read_value =
    (bus_req.addr == tcoc_pkg::REG_CONTROL)   ? img_control :
    (bus_req.addr == tcoc_pkg::REG_OUT_MODE)  ? img_out_mode :
    (bus_req.addr == tcoc_pkg::REG_COUNTER)   ? counter_value :
    (bus_req.addr == tcoc_pkg::REG_COMPARE_A) ? channel_compare_value[0] :
    (bus_req.addr == tcoc_pkg::REG_COMPARE_B) ? channel_compare_value[1] :
    (bus_req.addr == tcoc_pkg::REG_COMPARE_C) ? channel_compare_value[2] :
    (bus_req.addr == tcoc_pkg::REG_CAPTURE)   ? capture_register :
    (bus_req.addr == tcoc_pkg::REG_FLAGS)     ? img_flags :
    (bus_req.addr == tcoc_pkg::REG_OUT_BITS)  ? img_out_bits :
                                                16'h0000;

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_rdata <= 16'h0000;
    end else begin
      bus_rdata <= bus_req.rd ? read_value : 16'h0000;
    end
  end

  assign flag_status = flags;

endmodule : tcoc_timer_compare_output

// >>> testbench/tcoc_sva.sv
// Checker for the timer compare output block, bound to its top module.
// Assumes only top module ports; output modes and waveform mode are shadowed.
`timescale 1ns/1ps
module tcoc_sva (
  input wire logic                       sys_clk,
  input wire logic                       sys_rst,
  input wire tcoc_pkg::tcoc_bus_req_type bus_req,
  input wire logic [15:0]                bus_rdata,
  input wire logic [2:0]                 port_value,
  input wire logic [2:0]                 pin_direction_bit,
  input wire logic [4:0]                 flag_int_ack,
  input wire tcoc_pkg::tcoc_pin_type     pin_drive,
  input wire logic [2:0]                 compare_output_bit,
  input wire logic [4:0]                 flag_status
);
  logic [5:0] om;
  logic [3:0] wmode;
  wire        om_wr = bus_req.wr && bus_req.addr == tcoc_pkg::REG_OUT_MODE;
  wire        md_wr = bus_req.wr && bus_req.addr == tcoc_pkg::REG_CONTROL;
  wire [2:0]  sel = {|om[5:4], |om[3:2], |om[1:0]};
  wire        npwm = wmode == 4'h0 || wmode == 4'h4 || wmode == 4'hC;
  wire        force_a = bus_req.wr && bus_req.addr == tcoc_pkg::REG_FORCE && bus_req.wdata[0];
  wire        fl_wr = bus_req.wr && bus_req.addr == tcoc_pkg::REG_FLAGS;
  wire        flag_hold = !fl_wr && flag_int_ack == 5'h00;

  // Shadows the mode fields so pin and force checks need no internal probes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      om <= 6'h00;
      wmode <= 4'h0;
    end else begin
      if (om_wr) om <= bus_req.wdata[5:0];
      if (md_wr) wmode <= bus_req.wdata[3:0];
    end
  end

  sequence cnt_wr;
    bus_req.wr && bus_req.addr == tcoc_pkg::REG_COUNTER;
  endsequence
  sequence cnt_rd;
    bus_req.rd && bus_req.addr == tcoc_pkg::REG_COUNTER;
  endsequence

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  oe_follows_dir_a: assert property (pin_drive.oe_n == ~pin_direction_bit)
    else $error("pin enable differs from direction");
  pin_source_a: assert property (
    pin_drive.value == ((sel & compare_output_bit) | (~sel & port_value)))
    else $error("pin level has wrong source");
  reset_clear_a: assert property ($fell(sys_rst) |-> compare_output_bit == 3'h0)
    else $error("compare bits not cleared by reset");
  mode_zero_hold_a: assert property (om[1:0] == 2'b00 |=> $stable(compare_output_bit[0]))
    else $error("compare bit moved with output mode zero");
  flags_only_set_a: assert property (
    flag_hold |=> (flag_status & $past(flag_status)) == $past(flag_status))
    else $error("flag cleared without write or acknowledge");
  force_action_a: assert property (
    force_a && npwm && om[1] |=> compare_output_bit[0] == $past(om[0]))
    else $error("force did not apply set or clear");
  counter_rw_a: assert property (cnt_wr ##1 cnt_rd |=> bus_rdata == $past(bus_req.wdata, 2))
    else $error("counter write not read back");
  read_bits_a: assert property (
    bus_req.rd && bus_req.addr == tcoc_pkg::REG_OUT_BITS |=>
    bus_rdata[2:0] == $past(compare_output_bit))
    else $error("output bits read wrong");
  read_idle_a: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data outside read slot");
endmodule : tcoc_sva

bind tcoc_timer_compare_output tcoc_sva i_tcoc_sva (.sys_clk, .sys_rst, .bus_req,
  .bus_rdata, .port_value, .pin_direction_bit, .flag_int_ack, .pin_drive,
  .compare_output_bit, .flag_status);

// >>> testbench/tcoc_timer_compare_output_bench.sv
// Self-checking bench for the timer compare output block.
// Assumes the block alone on a 20 MHz clock; reads are checked from a queue.
`timescale 1ns/1ps
module tcoc_timer_compare_output_bench;
  logic                       sys_clk = 1'b0;
  logic                       sys_rst = 1'b1;
  tcoc_pkg::tcoc_bus_req_type bus_req = '0;
  logic [15:0]                bus_rdata;
  logic [2:0]                 port_value = 3'h5;
  logic [2:0]                 pin_direction_bit = 3'h0;
  logic                       capture_event = 1'b0;
  logic [4:0]                 flag_int_ack = 5'h00;
  tcoc_pkg::tcoc_pin_type     pin_drive;
  logic [2:0]                 compare_output_bit;
  logic [4:0]                 flag_status;
  logic [15:0]                exp_q[$];
  logic                       rd_was = 1'b0;
  logic [15:0]                v;
  int                         fail_count = 0;
  int                         n_checks = 0;
  int                         n;
  int                         t0;

  tcoc_timer_compare_output i_tcoc_timer_compare_output (.sys_clk, .sys_rst, .bus_req,
    .bus_rdata, .port_value, .pin_direction_bit, .capture_event, .flag_int_ack,
    .pin_drive, .compare_output_bit, .flag_status);

  always #25 sys_clk = ~sys_clk;

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task print_verdict;
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk) rd_was <= bus_req.rd;
  always @(negedge sys_clk) begin
    if (rd_was === 1'b1) check("read data", bus_rdata, exp_q.pop_front());
  end

  task wr(input logic [3:0] a, input logic [15:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
  endtask : wr

  task rd(input logic [3:0] a, input logic [15:0] e);
    bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    exp_q.push_back(e);
    @(posedge sys_clk);
  endtask : rd

  task idle(input int k);
    bus_req <= '0;
    repeat (k) @(posedge sys_clk);
  endtask : idle

  // Bounded wait for channel A to change, sampled at falling edges where it is settled
  task wait_edge(output int c);
    logic b;
    b = compare_output_bit[0];
    c = 0;
    while (compare_output_bit[0] === b && c < 2000) begin
      @(negedge sys_clk);
      c++;
    end
  endtask : wait_edge

  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    v = 16'($urandom(32'hda795089));
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    wr(4'hA, 16'hFFFF);
    for (int a = 0; a < 16; a++) rd(a[3:0], 16'h0000);
    // Output mode per step: set, clear, toggle, toggle, none
    for (int i = 0; i < 5; i++) begin
      wr(tcoc_pkg::REG_OUT_MODE, {6'h00, 10'h05B >> (2 * i)});
      wr(tcoc_pkg::REG_FORCE, 16'h0001);
      rd(tcoc_pkg::REG_OUT_BITS, {15'h0000, 1'(5'h05 >> i)});
    end
    rd(tcoc_pkg::REG_FLAGS, 16'h0000);
    rd(tcoc_pkg::REG_COUNTER, 16'h0000);
    wr(tcoc_pkg::REG_OUT_MODE, 16'h0003);
    pin_direction_bit <= 3'h1;
    idle(1);
    @(negedge sys_clk);
    check("pin enable", {13'h0000, pin_drive.oe_n}, 16'h0006);
    check("pin level", {13'h0000, pin_drive.value}, 16'h0004);
    @(posedge sys_clk);
    wr(tcoc_pkg::REG_OUT_MODE, 16'h003F);
    wr(tcoc_pkg::REG_COUNTER, v);
    capture_event <= 1'b1;
    rd(tcoc_pkg::REG_COUNTER, v);
    capture_event <= 1'b0;
    rd(tcoc_pkg::REG_CAPTURE, v);
    rd(tcoc_pkg::REG_FLAGS, 16'h0010);
    wr(tcoc_pkg::REG_FLAGS, 16'h001F);
    rd(tcoc_pkg::REG_FLAGS, 16'h0000);
    wr(tcoc_pkg::REG_COMPARE_A, 16'hFFFD);
    wr(tcoc_pkg::REG_COMPARE_B, 16'h8000);
    wr(tcoc_pkg::REG_COMPARE_C, 16'h8000);
    wr(tcoc_pkg::REG_COUNTER, 16'hFFFD);
    wr(tcoc_pkg::REG_CONTROL, 16'h0010);
    idle(4);
    wr(tcoc_pkg::REG_CONTROL, 16'h0000);
    rd(tcoc_pkg::REG_COUNTER, 16'h0002);
    rd(tcoc_pkg::REG_FLAGS, 16'h0001);
    flag_int_ack <= 5'h01;
    idle(1);
    flag_int_ack <= 5'h00;
    rd(tcoc_pkg::REG_FLAGS, 16'h0000);
    // Mode 4 at full rate, then mode 12 through the divide-by-8 prescaler
    for (int i = 0; i < 2; i++) begin
      n = 1 + $urandom % 6;
      wr(tcoc_pkg::REG_OUT_MODE, 16'h0001);
      wr(tcoc_pkg::REG_COMPARE_A, n[15:0]); // top only changed while stopped
      wr(tcoc_pkg::REG_CAPTURE, n[15:0]);
      wr(tcoc_pkg::REG_COUNTER, 16'h0000);
      wr(tcoc_pkg::REG_CONTROL, (i == 1) ? 16'h002C : 16'h0014);
      idle(1);
      @(negedge sys_clk);
      wait_edge(t0);
      wait_edge(t0);
      v = ((i == 1) ? 16'h0008 : 16'h0001) * (n[15:0] + 16'h0001);
      check("half period", t0[15:0], v);
      @(posedge sys_clk);
      wr(tcoc_pkg::REG_CONTROL, 16'h0000);
      rd(tcoc_pkg::REG_FLAGS, (i == 1) ? 16'h0012 : 16'h0002);
      wr(tcoc_pkg::REG_FLAGS, 16'h001F);
    end
    // Fast PWM code: force ignored, a match in clear mode drives the bit high
    wr(tcoc_pkg::REG_OUT_MODE, 16'h0002);
    wr(tcoc_pkg::REG_FORCE, 16'h0001);
    wr(tcoc_pkg::REG_CONTROL, 16'h0005);
    wr(tcoc_pkg::REG_OUT_MODE, 16'h0003);
    wr(tcoc_pkg::REG_FORCE, 16'h0001);
    rd(tcoc_pkg::REG_OUT_BITS, 16'h0000);
    wr(tcoc_pkg::REG_OUT_MODE, 16'h0002);
    wr(tcoc_pkg::REG_COMPARE_A, 16'h0003);
    wr(tcoc_pkg::REG_COUNTER, 16'h0000);
    wr(tcoc_pkg::REG_CONTROL, 16'h0035);
    idle(300);
    wr(tcoc_pkg::REG_CONTROL, 16'h0000);
    rd(tcoc_pkg::REG_OUT_BITS, 16'h0001);
    rd(tcoc_pkg::REG_COUNTER, 16'h0004);
    rd(tcoc_pkg::REG_FLAGS, 16'h0002);
    idle(3);
    print_verdict();
  end
endmodule : tcoc_timer_compare_output_bench
